/* rtl/cagc_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing figures of the cell gain block.
// Assumes: Control clock mclk at 20 MHz.
// Notes:   Definitions only.
`ifndef CAGC_CFG_SVH
`define CAGC_CFG_SVH
`define CAGC_ADDR_W          7
`define CAGC_OFF_CELL_CTRL   7'h24
`define CAGC_OFF_DRV_STAT    7'h25
`define CAGC_OFF_IRQ_STAT    7'h40
`define CAGC_OFF_IRQ_MASK    7'h41
`define CAGC_CELL_RESET      16'h0000
`define CAGC_CELL_WR_MASK    16'h3fff
`define CAGC_DRV_RESET       16'hfc00
`define CAGC_DRV_WR_MASK     16'h03f0
`define CAGC_DRV_FLAG_LSB    10
`define CAGC_CLK_MHZ         20
`define CAGC_POP_SHORT_MS    802
`define CAGC_POP_LONG_MS     4006
`define CAGC_IRQ_RESET       8'h00
`endif

/* rtl/cagc_pkg.sv */
// Purpose: Types shared by the cell gain register block.
// Assumes: Field layout follows the register table.
// Notes:   Structs are packed MSB first to match the register words.
package cagc_pkg;
  typedef struct packed {
    logic       rsvd;
    logic       cell_noise_flag;
    logic [2:0] noise_threshold_sel;
    logic [1:0] cell_hysteresis_sel;
    logic       cell_clip_step_en;
    logic [2:0] cell_target_level;
    logic [3:0] cell_time_const_sel;
    logic       cell_gain_loop_en;
  } cagc_cell_ctrl_type;
  typedef struct packed {
    logic [5:0] off_flags;
    logic       headphone_pop_reduce_en;
    logic       buzzer_route_disable;
    logic       speaker_two_to_buzzer_en;
    logic       speaker_one_to_buzzer_en;
    logic       pop_sequence_disable;
    logic       pop_sequence_duration;
    logic [3:0] rsvd;
  } cagc_drv_ctrl_type;
  typedef enum logic [1:0] {
    CAGC_POP_IDLE = 2'b00,
    CAGC_POP_RUN  = 2'b01,
    CAGC_POP_DONE = 2'b11
  } cagc_pop_state_type;
endpackage : cagc_pkg

/* rtl/cagc_regs.sv */
// Purpose: Cell input gain control and driver power-down status registers.
// Assumes: Live status inputs come from other clock domains and are synchronised here.
// Notes:   Register port answers every access; unmapped reads return zero.
`include "cagc_cfg.svh"
module cagc_regs #(
  parameter int unsigned POP_SHORT_CYC = `CAGC_POP_SHORT_MS * 1000 * `CAGC_CLK_MHZ,
  parameter int unsigned POP_LONG_CYC  = `CAGC_POP_LONG_MS * 1000 * `CAGC_CLK_MHZ
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  // Register port
  input  wire logic [`CAGC_ADDR_W-1:0]   reg_addr,
  input  wire logic [15:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [15:0]               reg_rdata,
  // Live status from the analog side
  input  wire logic                      below_noise_in,
  input  wire logic [5:0]                driver_off_in,
  input  wire logic                      pop_start,
  // Controls to the analog side
  output cagc_pkg::cagc_cell_ctrl_type   cell_ctrl,
  output cagc_pkg::cagc_drv_ctrl_type    drv_ctrl,
  output logic                           pop_busy,
  output logic                           irq
);
  import cagc_pkg::*;

  logic [15:0]         cell_q;
  logic [15:0]         drv_q;
  logic                noise_s1_q;
  logic                noise_s2_q;
  logic [5:0]          off_s1_q;
  logic [5:0]          off_s2_q;
  logic                pop_s1_q;
  logic                pop_s2_q;
  logic                pop_s3_q;
  logic                noise_prev_q;
  logic [5:0]          off_prev_q;
  logic [7:0]          irq_stat_q;
  logic [7:0]          irq_mask_q;
  logic [31:0]         pop_cnt_q;
  cagc_pop_state_type  pop_state_q;
  logic                pop_done_ev;
  logic [7:0]          events;
  logic [15:0]         cell_view;
  logic [15:0]         drv_view;

  function automatic logic hit(input logic [`CAGC_ADDR_W-1:0] a,
                               input logic [`CAGC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // Level inputs come from other domains, so two flops before use.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      noise_s1_q <= 1'b0;
      noise_s2_q <= 1'b0;
      off_s1_q   <= 6'h3f;
      off_s2_q   <= 6'h3f;
      pop_s1_q   <= 1'b0;
      pop_s2_q   <= 1'b0;
      pop_s3_q   <= 1'b0;
    end else begin
      noise_s1_q <= below_noise_in;
      noise_s2_q <= noise_s1_q;
      off_s1_q   <= driver_off_in;
      off_s2_q   <= off_s1_q;
      pop_s1_q   <= pop_start;
      pop_s2_q   <= pop_s1_q;
      pop_s3_q   <= pop_s2_q;
    end
  end

  // Read views: flag is meaningful only while the loop runs, so it reads 0 otherwise.
  always_comb begin
    cell_view     = cell_q & 16'h3fff;
    cell_view[14] = noise_s2_q & cell_q[0];
    drv_view      = {off_s2_q, drv_q[9:4], 4'h0};
  end

  // Cell control writes; reserved and flag bits are masked off.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cell_q <= `CAGC_CELL_RESET;
    end else if (reg_wr && hit(reg_addr, `CAGC_OFF_CELL_CTRL)) begin
      cell_q <= reg_wdata & `CAGC_CELL_WR_MASK & 16'hbfff;
    end
  end

  // Driver control writes; status flags ignore writes.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drv_q <= `CAGC_DRV_RESET;
    end else if (reg_wr && hit(reg_addr, `CAGC_OFF_DRV_STAT)) begin
      drv_q <= (reg_wdata & `CAGC_DRV_WR_MASK) | `CAGC_DRV_RESET;
    end
  end

  // Read data stand one cycle after the strobe only.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, `CAGC_OFF_CELL_CTRL))      reg_rdata <= cell_view;
      else if (hit(reg_addr, `CAGC_OFF_DRV_STAT))  reg_rdata <= drv_view;
      else if (hit(reg_addr, `CAGC_OFF_IRQ_STAT))  reg_rdata <= {8'h00, irq_stat_q};
      else if (hit(reg_addr, `CAGC_OFF_IRQ_MASK))  reg_rdata <= {8'h00, irq_mask_q};
      else                                         reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Pop sequence timer; a start while sequencing is suppressed is ignored and the timer stays idle.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pop_state_q <= CAGC_POP_IDLE;
      pop_cnt_q   <= 32'h0000_0000;
    end else begin
      unique case (pop_state_q)
        CAGC_POP_IDLE: begin
          if (pop_s2_q && !pop_s3_q && !drv_q[5]) begin
            pop_state_q <= CAGC_POP_RUN;
            pop_cnt_q   <= drv_q[4] ? POP_LONG_CYC - 32'd1 : POP_SHORT_CYC - 32'd1;
          end
        end
        CAGC_POP_RUN: begin
          if (pop_cnt_q == 32'h0000_0000) begin
            pop_state_q <= CAGC_POP_DONE;
          end else begin
            pop_cnt_q <= pop_cnt_q - 32'd1;
          end
        end
        CAGC_POP_DONE: begin
          pop_state_q <= CAGC_POP_IDLE;
        end
        default: begin
          pop_state_q <= CAGC_POP_IDLE;
        end
      endcase
    end
  end

  assign pop_done_ev = (pop_state_q == CAGC_POP_DONE);

  // Event sources: noise flag edges, any driver flag change, pop end.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      noise_prev_q <= 1'b0;
      off_prev_q   <= 6'h3f;
    end else begin
      noise_prev_q <= cell_view[14];
      off_prev_q   <= off_s2_q;
    end
  end

  always_comb begin
    events      = 8'h00;
    events[0]   = cell_view[14] ^ noise_prev_q;
    events[1]   = |(off_s2_q ^ off_prev_q);
    events[2]   = pop_done_ev;
  end

  // Sticky status: a set in the clearing cycle wins.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= `CAGC_IRQ_RESET;
    end else begin
      if (reg_wr && hit(reg_addr, `CAGC_OFF_IRQ_STAT)) begin
        irq_stat_q <= (irq_stat_q & ~reg_wdata[7:0]) | events;
      end else begin
        irq_stat_q <= irq_stat_q | events;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_q <= `CAGC_IRQ_RESET;
    end else if (reg_wr && hit(reg_addr, `CAGC_OFF_IRQ_MASK)) begin
      irq_mask_q <= reg_wdata[7:0];
    end
  end

  // Outputs all come from flops.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cell_ctrl <= '0;
      drv_ctrl  <= `CAGC_DRV_RESET;
      pop_busy  <= 1'b0;
      irq       <= 1'b0;
    end else begin
      cell_ctrl <= cell_view;
      drv_ctrl  <= drv_view;
      pop_busy  <= (pop_state_q == CAGC_POP_RUN);
      irq       <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Flags that reach software must follow the synchronised inputs.
  AST_NOISE_GATED: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_rd && reg_addr == `CAGC_OFF_CELL_CTRL) |=>
      reg_rdata[14] == $past(noise_s2_q & cell_q[0]))
    else $error("Noise flag read does not match live gated flag.");

  AST_DRV_LIVE: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_rd && reg_addr == `CAGC_OFF_DRV_STAT) |=> reg_rdata[15:10] == $past(off_s2_q))
    else $error("Driver flags read are not the live values.");

  AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_rdata[15] == 1'b0 || !$past(reg_rd) || $past(reg_addr) != `CAGC_OFF_CELL_CTRL)
    else $error("Reserved cell bit read as one.");

  AST_DRV_RSVD: assert property (@(posedge mclk) disable iff (!rst_b)
    $past(reg_rd) && $past(reg_addr) == `CAGC_OFF_DRV_STAT |-> reg_rdata[3:0] == 4'h0)
    else $error("Reserved driver bits read as nonzero.");

  AST_FLAG_NO_WR: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_wr && reg_addr == `CAGC_OFF_CELL_CTRL) |=> cell_q[14] == 1'b0)
    else $error("Noise flag took a written value.");

  AST_CELL_WR: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_wr && reg_addr == `CAGC_OFF_CELL_CTRL) |=> cell_q[13:0] == $past(reg_wdata[13:0]))
    else $error("Cell control write not stored.");

  AST_DRV_WR: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_wr && reg_addr == `CAGC_OFF_DRV_STAT) |=> drv_q[9:4] == $past(reg_wdata[9:4]) ##1
      drv_ctrl[9:4] == $past(drv_q[9:4]))
    else $error("Driver control write not stored or forwarded.");

  sequence pop_go_s;
    pop_state_q == CAGC_POP_IDLE && pop_s2_q && !pop_s3_q;
  endsequence

  AST_POP_SUPPRESS: assert property (@(posedge mclk) disable iff (!rst_b)
    (pop_go_s and drv_q[5]) |=> pop_state_q == CAGC_POP_IDLE)
    else $error("Pop sequence ran while suppressed.");

  AST_POP_LEN: assert property (@(posedge mclk) disable iff (!rst_b)
    (pop_go_s and !drv_q[5]) |=> pop_cnt_q ==
      (drv_q[4] ? POP_LONG_CYC - 32'd1 : POP_SHORT_CYC - 32'd1))
    else $error("Pop sequence length wrong for duration bit.");

  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!rst_b)
    |(irq_stat_q & irq_mask_q) |=> irq)
    else $error("Interrupt not raised for unmasked status.");

  // The line must also drop, or a cleared source would keep software in its handler.
  AST_IRQ_QUIET: assert property (@(posedge mclk) disable iff (!rst_b)
    !(|(irq_stat_q & irq_mask_q)) |=> !irq)
    else $error("Interrupt raised with no unmasked status.");

  AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("Read data not zero outside a read.");

  AST_UNMAPPED_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_rd && reg_addr != `CAGC_OFF_CELL_CTRL && reg_addr != `CAGC_OFF_DRV_STAT &&
     reg_addr != `CAGC_OFF_IRQ_STAT && reg_addr != `CAGC_OFF_IRQ_MASK) |=>
      reg_rdata == 16'h0000)
    else $error("Unmapped read returned nonzero data.");

  AST_CELL_RD: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_rd && reg_addr == `CAGC_OFF_CELL_CTRL) |=>
      reg_rdata[13:0] == $past(cell_q[13:0]))
    else $error("Cell control read does not match stored fields.");

  AST_DRV_RD_CTRL: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_rd && reg_addr == `CAGC_OFF_DRV_STAT) |=>
      reg_rdata[9:4] == $past(drv_q[9:4]))
    else $error("Driver control read does not match stored bits.");

  AST_CELL_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    !(reg_wr && reg_addr == `CAGC_OFF_CELL_CTRL) |=> $stable(cell_q))
    else $error("Cell control changed without a write.");

  AST_DRV_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    !(reg_wr && reg_addr == `CAGC_OFF_DRV_STAT) |=> $stable(drv_q))
    else $error("Driver control changed without a write.");

  AST_DRV_RSVD_STORE: assert property (@(posedge mclk) disable iff (!rst_b)
    drv_q[3:0] == 4'h0)
    else $error("Reserved driver bits stored a one.");

  AST_CELL_FOLLOW: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |=> cell_ctrl == $past(cell_view))
    else $error("Cell control output lags its register.");

  AST_DRV_FOLLOW: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |=> drv_ctrl == $past(drv_view))
    else $error("Driver control output lags its register.");

  AST_NOISE_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
    !cell_q[0] |-> !cell_view[14])
    else $error("Noise flag shown while the gain loop is off.");

  AST_NOISE_EVENT: assert property (@(posedge mclk) disable iff (!rst_b)
    (cell_view[14] != noise_prev_q) |=> irq_stat_q[0])
    else $error("Noise flag change not recorded.");

  AST_DRV_EVENT: assert property (@(posedge mclk) disable iff (!rst_b)
    (off_s2_q != off_prev_q) |=> irq_stat_q[1])
    else $error("Driver flag change not recorded.");

  AST_POP_EVENT: assert property (@(posedge mclk) disable iff (!rst_b)
    pop_done_ev |=> irq_stat_q[2])
    else $error("Pop end not recorded.");

  // A set driver status bit must stay set until a one is written to it.
  AST_STAT_STICKY: assert property (@(posedge mclk) disable iff (!rst_b)
    (irq_stat_q[1] && !(reg_wr && reg_addr == `CAGC_OFF_IRQ_STAT && reg_wdata[1])) |=>
      irq_stat_q[1])
    else $error("Driver status bit lost without a clear.");

  AST_STAT_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_wr && reg_addr == `CAGC_OFF_IRQ_STAT && reg_wdata[1] && !events[1]) |=>
      !irq_stat_q[1])
    else $error("Driver status bit not cleared by a one.");

  AST_MASK_WR: assert property (@(posedge mclk) disable iff (!rst_b)
    (reg_wr && reg_addr == `CAGC_OFF_IRQ_MASK) |=> irq_mask_q == $past(reg_wdata[7:0]))
    else $error("Mask write not stored.");

  sequence pop_last_s;
    pop_state_q == CAGC_POP_RUN && pop_cnt_q == 32'h0000_0000;
  endsequence

  sequence pop_step_s;
    pop_state_q == CAGC_POP_RUN && pop_cnt_q != 32'h0000_0000;
  endsequence

  AST_POP_STEP: assert property (@(posedge mclk) disable iff (!rst_b)
    pop_step_s |=> pop_cnt_q == $past(pop_cnt_q) - 32'd1)
    else $error("Pop timer did not count down by one.");

  AST_POP_END: assert property (@(posedge mclk) disable iff (!rst_b)
    pop_last_s |=> pop_state_q == CAGC_POP_DONE ##1 pop_state_q == CAGC_POP_IDLE)
    else $error("Pop timer did not finish in order.");

  AST_POP_BUSY: assert property (@(posedge mclk) disable iff (!rst_b)
    (pop_state_q == CAGC_POP_RUN) |=> pop_busy)
    else $error("Busy low while the pop timer runs.");

  AST_POP_IDLE: assert property (@(posedge mclk) disable iff (!rst_b)
    (pop_state_q != CAGC_POP_RUN) |=> !pop_busy)
    else $error("Busy high while the pop timer is stopped.");
endmodule : cagc_regs

/* verif/cagc_tb.sv */
// Purpose: Self-checking bench for the cell gain and driver status registers.
// Assumes: Pop timer parameters are shortened to 20 and 50 cycles.
// Notes:   Tasks leave one idle cycle between strobes so no signal is driven twice at an edge.
`include "cagc_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cagc_pkg::*;
  localparam int PS = 20;
  localparam int PL = 50;
  logic               mclk;
  logic               rst_b;
  logic [6:0]         reg_addr;
  logic [15:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [15:0]        reg_rdata;
  logic               below_noise_in;
  logic [5:0]         driver_off_in;
  logic               pop_start;
  cagc_cell_ctrl_type cell_ctrl;
  cagc_drv_ctrl_type  drv_ctrl;
  logic               pop_busy;
  logic               irq;
  int                 num_errors = 0;
  int                 compares = 0;
  int                 n;
  logic [3:0]         k;

  cagc_regs #(.POP_SHORT_CYC(PS), .POP_LONG_CYC(PL)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .below_noise_in(below_noise_in), .driver_off_in(driver_off_in), .pop_start(pop_start),
    .cell_ctrl(cell_ctrl), .drv_ctrl(drv_ctrl), .pop_busy(pop_busy), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic close_out();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [15:0] e, input string nm);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
    @(posedge mclk);
  endtask : rd

  // Pulses the start input and counts the cycles in which the timer reports busy.
  task automatic pop(output int c);
    c = 0;
    pop_start <= 1'b1;
    for (int i = 0; i < 90; i++) begin
      @(posedge mclk);
      if (i == 8) pop_start <= 1'b0;
      #1 if (pop_busy === 1'b1) c++;
    end
    @(posedge mclk);
  endtask : pop

  initial begin
    #(50 * 6000);
    num_errors++;
    close_out();
  end

  initial begin
    rst_b = 1'b0; reg_addr = 7'h00; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
    below_noise_in = 1'b0; driver_off_in = 6'h3f; pop_start = 1'b0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`CAGC_OFF_CELL_CTRL, 16'h0000, "cell reset");
    rd(`CAGC_OFF_DRV_STAT, 16'hfc00, "drv reset");
    chk("drv_ctrl reset", 16'hfc00, drv_ctrl);
    // Every code of every field except the loop enable, held at zero, with the read-only flag bit written as one.
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      wr(`CAGC_OFF_CELL_CTRL, {2'b01, k[2:0], k[1:0], k[0], ~k[2:0], k, 1'b0});
      rd(`CAGC_OFF_CELL_CTRL, {2'b00, k[2:0], k[1:0], k[0], ~k[2:0], k, 1'b0}, "cell");
      chk("cell_ctrl", {2'b00, k[2:0], k[1:0], k[0], ~k[2:0], k, 1'b0}, cell_ctrl);
    end
    wr(`CAGC_OFF_CELL_CTRL, 16'h0001);
    below_noise_in <= 1'b1;
    repeat (5) @(posedge mclk);
    rd(`CAGC_OFF_CELL_CTRL, 16'h4001, "noise set");
    below_noise_in <= 1'b0;
    repeat (5) @(posedge mclk);
    rd(`CAGC_OFF_CELL_CTRL, 16'h0001, "noise live");
    wr(`CAGC_OFF_DRV_STAT, 16'hfff0);
    driver_off_in <= 6'b101010;
    repeat (5) @(posedge mclk);
    rd(`CAGC_OFF_DRV_STAT, 16'habf0, "drv flags");
    wr(`CAGC_OFF_DRV_STAT, 16'h0000);
    rd(`CAGC_OFF_DRV_STAT, 16'ha800, "drv clear");
    rd(7'h26, 16'h0000, "unmapped");
    // Interrupt: masked event stays quiet, unmasked one raises the line, clear drops it.
    wr(`CAGC_OFF_IRQ_STAT, 16'h00ff);
    rd(`CAGC_OFF_IRQ_STAT, 16'h0000, "irq clear");
    driver_off_in <= 6'b010101;
    repeat (5) @(posedge mclk);
    chk("irq masked", 16'h0000, {15'h0, irq});
    wr(`CAGC_OFF_IRQ_MASK, 16'h0006);
    rd(`CAGC_OFF_IRQ_STAT, 16'h0002, "irq drv");
    chk("irq on", 16'h0001, {15'h0, irq});
    wr(`CAGC_OFF_IRQ_STAT, 16'h0002);
    repeat (2) @(posedge mclk);
    chk("irq off", 16'h0000, {15'h0, irq});
    // Pop timer, short then long, then suppressed.
    pop(n);
    chk("pop short", 16'h0001, {15'h0, (n >= PS && n <= PS + 1)});
    rd(`CAGC_OFF_IRQ_STAT, 16'h0004, "pop done");
    chk("irq pop", 16'h0001, {15'h0, irq});
    wr(`CAGC_OFF_IRQ_STAT, 16'h0004);
    wr(`CAGC_OFF_DRV_STAT, 16'h0010);
    pop(n);
    chk("pop long", 16'h0001, {15'h0, (n >= PL && n <= PL + 1)});
    wr(`CAGC_OFF_DRV_STAT, 16'h0020);
    pop(n);
    chk("pop off", 16'h0000, 16'(n));
    close_out();
  end
endmodule : testbench
